// ---- core/sas_seq.sv ----
// sequencer for the successive-approximation converter
`timescale 1ns/1ps
`default_nettype none
module sas_seq
   import sas_pkg::*;
#(
   parameter int NCH = 8
) (
   input  wire logic        i_sys_clk,
   input  wire logic        i_rstn,
   input  wire logic [3:0]  i_addr,
   input  wire logic [15:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [15:0] o_rdata,
   input  wire logic        i_cmp_hi,
   output logic      [2:0]  o_mux_sel,
   output logic             o_mux_alt,
   output logic             o_sample,
   output logic             o_vref_on,
   output logic      [9:0]  o_dac_code,
   output logic             o_conv_irq
);
   sas_ctrl0_t ctrl0_reg, ctrl0_next;
   sas_ctrl1_t ctrl1_reg, ctrl1_next;
   sas_state_t state_reg, state_next;
   logic [1:0] div_reg, div_next;
   logic [6:0] cyc_reg, cyc_next;
   logic [9:0] sar_reg, sar_next;
   logic [3:0] bit_reg, bit_next;
   logic [2:0] ch_reg, ch_next;
   logic [2:0] unsel_reg, unsel_next;
   logic       last_sel_reg, last_sel_next;
   logic       irq_reg, irq_next;
   logic [9:0] res_reg [NCH];
   logic [15:0] rdata_reg, rdata_next;
   logic       tick;
   logic       done;
   logic [6:0] term;
   logic [6:0] sar_start;
   logic [2:0] nsel_last;

   // sweep length code 0..3 selects 2,4,6,8 pins (at most 5 when alt is set); rsweep1 selects 1..4 pins
   function automatic logic [2:0] last_chan(input sas_ctrl0_t c0, input sas_ctrl1_t c1);
      logic [2:0] n;
      n = 3'h0;
      if (c0.mode == SAS_MODE_RSWEEP1) begin
         n = {1'b0, c1.sweep};
      end else begin
         n = {c1.sweep, 1'b1};
      end
      if (c0.alt && n > SAS_ALT_LAST) begin
         n = SAS_ALT_LAST;
      end
      return n;
   endfunction

   // divided conversion clock as a one-cycle enable
   always_comb begin
      div_next = 2'h0;
      // no tick while idle, so a finished conversion never looks like a fresh divider phase
      tick = 1'b0;
      if (state_reg == SAS_ST_CONV) begin
         div_next = div_reg + 2'h1;
         case (ctrl1_reg.div)
            SAS_DIV2: begin
               tick = div_reg[0];
            end
            SAS_DIV4: begin
               tick = (div_reg == 2'h3);
            end
            default: begin
               tick = 1'b1;
            end
         endcase
      end
   end

   // terminal count by resolution and hold
   always_comb begin
      if (ctrl1_reg.sh) begin
         term = ctrl1_reg.res10 ? SAS_CYC_SH10 : SAS_CYC_SH8;
      end else begin
         term = ctrl1_reg.res10 ? SAS_CYC_NS10 : SAS_CYC_NS8;
      end
      // approximation occupies the last cycles of the window
      sar_start = term - 7'(ctrl1_reg.res10 ? SAS_BITS10 : SAS_BITS8);
   end

   // a cleared start flag aborts the conversion with no store
   assign done = (state_reg == SAS_ST_CONV) && ctrl0_reg.start && tick && (cyc_reg == term - 7'h1);
   assign nsel_last = last_chan(ctrl0_reg, ctrl1_reg);

   always_comb begin
      ctrl0_next = ctrl0_reg;
      ctrl1_next = ctrl1_reg;
      state_next = state_reg;
      cyc_next = cyc_reg;
      sar_next = sar_reg;
      bit_next = bit_reg;
      ch_next = ch_reg;
      unsel_next = unsel_reg;
      last_sel_next = last_sel_reg;
      irq_next = irq_reg;
      rdata_next = 16'h0000;
      if (i_wr && i_addr == SAS_OFS_CTRL0) begin
         ctrl0_next = sas_ctrl0_t'(i_wdata[7:0]);
      end
      if (i_wr && i_addr == SAS_OFS_CTRL1) begin
         ctrl1_next = sas_ctrl1_t'(i_wdata[6:0]);
      end
      if (i_wr && i_addr == SAS_OFS_STATUS && i_wdata[0]) begin
         irq_next = 1'b0;
      end
      if (i_rd) begin
         case (i_addr)
            SAS_OFS_CTRL0:  rdata_next = {8'h00, ctrl0_reg};
            SAS_OFS_CTRL1:  rdata_next = {9'h000, ctrl1_reg};
            SAS_OFS_STATUS: rdata_next = {12'h000, ch_reg, irq_reg};
            default: begin
               if (i_addr[3]) begin
                  rdata_next = {6'h00, res_reg[i_addr[2:0]]};
               end
            end
         endcase
      end
      case (state_reg)
         SAS_ST_IDLE: begin
            if (ctrl0_next.start && !ctrl0_reg.start) begin
               state_next = SAS_ST_CONV;
               cyc_next = 7'h00;
               bit_next = 4'h9;
               sar_next = 10'h000;
               last_sel_next = 1'b0;
               unsel_next = 3'h0;
               // one-pin modes use the programmed channel, sweeps begin at 0
               ch_next = (ctrl0_next.mode == SAS_MODE_ONESHOT || ctrl0_next.mode == SAS_MODE_REPEAT)
                         ? ctrl0_next.chan : 3'h0;
            end
         end
         SAS_ST_CONV: begin
            if (!ctrl0_reg.start) begin
               state_next = SAS_ST_IDLE;
            end else if (tick) begin
               cyc_next = cyc_reg + 7'h1;
               // one bit trial per cycle, msb first
               if (cyc_reg >= sar_start) begin
                  sar_next[bit_reg] = i_cmp_hi;
                  if (bit_reg != 4'h0) begin
                     bit_next = bit_reg - 4'h1;
                  end
               end
               if (done) begin
                  cyc_next = 7'h00;
                  bit_next = 4'h9;
                  sar_next = 10'h000;
                  case (ctrl0_reg.mode)
                     SAS_MODE_ONESHOT: begin
                        irq_next = 1'b1;
                        ctrl0_next.start = 1'b0;
                        state_next = SAS_ST_IDLE;
                     end
                     SAS_MODE_SWEEP: begin
                        if (ch_reg == nsel_last) begin
                           irq_next = 1'b1;
                           ctrl0_next.start = 1'b0;
                           state_next = SAS_ST_IDLE;
                        end else begin
                           ch_next = ch_reg + 3'h1;
                        end
                     end
                     SAS_MODE_RSWEEP0: begin
                        ch_next = (ch_reg == nsel_last) ? 3'h0 : ch_reg + 3'h1;
                     end
                     SAS_MODE_RSWEEP1: begin
                        // selected pin, one unselected, back to 0
                        if (last_sel_reg) begin
                           last_sel_next = 1'b0;
                           ch_next = 3'h0;
                        end else if (ch_reg == nsel_last) begin
                           last_sel_next = 1'b1;
                           ch_next = nsel_last + 3'h1 + unsel_reg;
                           if (nsel_last + 3'h1 + unsel_reg == NCH - 1 || (ctrl0_reg.alt && ch_next == SAS_ALT_LAST)) begin
                              unsel_next = 3'h0;
                           end else begin
                              unsel_next = unsel_reg + 3'h1;
                           end
                        end else begin
                           ch_next = ch_reg + 3'h1;
                        end
                     end
                     default: begin
                        ch_next = ch_reg;
                     end
                  endcase
               end
            end
         end
         default: begin
            state_next = SAS_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         ctrl0_reg <= '{alt: 1'b0, start: 1'b0, chan: 3'h0, mode: SAS_MODE_ONESHOT};
         ctrl1_reg <= '{sweep: 2'h0, vref: 1'b0, sh: 1'b0, res10: 1'b0, div: SAS_DIV4};
         state_reg <= SAS_ST_IDLE;
         div_reg <= 2'h0;
         cyc_reg <= 7'h00;
         sar_reg <= 10'h000;
         bit_reg <= 4'h9;
         ch_reg <= 3'h0;
         unsel_reg <= 3'h0;
         last_sel_reg <= 1'b0;
         irq_reg <= 1'b0;
         rdata_reg <= 16'h0000;
      end else begin
         ctrl0_reg <= ctrl0_next;
         ctrl1_reg <= ctrl1_next;
         state_reg <= state_next;
         div_reg <= div_next;
         cyc_reg <= cyc_next;
         sar_reg <= sar_next;
         bit_reg <= bit_next;
         ch_reg <= ch_next;
         unsel_reg <= unsel_next;
         last_sel_reg <= last_sel_next;
         irq_reg <= irq_next;
         rdata_reg <= rdata_next;
      end
   end

   // result store; 8-bit results shift to low bits
   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         for (int i = 0; i < NCH; i++) begin
            res_reg[i] <= 10'h000;
         end
      end else if (done) begin
         // the last trial bit is still on the comparator in the done cycle
         res_reg[ch_reg] <= ctrl1_reg.res10 ? {sar_reg[9:1], i_cmp_hi} : {2'h0, sar_reg[9:3], i_cmp_hi};
      end
   end

   assign o_rdata = rdata_reg;
   assign o_mux_sel = ch_reg;
   assign o_mux_alt = ctrl0_reg.alt;
   // sample window: first 3 conversion cycles when sh is set, the whole conversion when it is clear
   assign o_sample = (state_reg == SAS_ST_CONV) && (!ctrl1_reg.sh || cyc_reg < SAS_CYC_SAMPLE);
   assign o_vref_on = ctrl1_reg.vref;
   assign o_dac_code = sar_reg | (10'h001 << bit_reg);
   assign o_conv_irq = irq_reg;

   chk_oneshot_stop: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (done && ctrl0_reg.mode == SAS_MODE_ONESHOT) |=> (irq_reg && state_reg == SAS_ST_IDLE && !ctrl0_reg.start))
      else $error("oneshot did not stop");
   chk_repeat_noirq: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (done && ctrl0_reg.mode == SAS_MODE_REPEAT && !irq_reg) |=> !irq_reg)
      else $error("repeat raised request");
   chk_rsweep1_noirq: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (done && ctrl0_reg.mode == SAS_MODE_RSWEEP1 && !irq_reg) |=> !irq_reg)
      else $error("weighted sweep raised request");
   chk_sweep_first: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (state_reg == SAS_ST_IDLE && state_next == SAS_ST_CONV && ctrl0_next.mode == SAS_MODE_SWEEP) |=> ch_reg == 3'h0)
      else $error("sweep not from channel 0");
   chk_sample_len: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (state_reg == SAS_ST_CONV && ctrl1_reg.sh && cyc_reg >= SAS_CYC_SAMPLE) |-> !o_sample)
      else $error("sample window too long");
   chk_term_count: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      done |-> (cyc_reg + 7'h1 == (ctrl1_reg.sh ? (ctrl1_reg.res10 ? SAS_CYC_SH10 : SAS_CYC_SH8)
                                               : (ctrl1_reg.res10 ? SAS_CYC_NS10 : SAS_CYC_NS8)))
               && (bit_reg == (ctrl1_reg.res10 ? 4'h0 : 4'h2)))
      else $error("wrong conversion length");
   chk_div_four: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (tick && state_reg == SAS_ST_CONV && ctrl1_reg.div == SAS_DIV4) |=> !tick [*3])
      else $error("divide by four broken");
   chk_res_eight: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (done && !ctrl1_reg.res10) |=> res_reg[$past(ch_reg)][9:8] == 2'h0)
      else $error("8-bit result not in low bits");
   cov_oneshot: cover property (@(posedge i_sys_clk) done && ctrl0_reg.mode == SAS_MODE_ONESHOT);
   cov_sweep_end: cover property (@(posedge i_sys_clk) done && ctrl0_reg.mode == SAS_MODE_SWEEP && irq_next);
   cov_rsweep1: cover property (@(posedge i_sys_clk) done && last_sel_reg);
endmodule
`default_nettype wire

// ---- core/sas_pkg.sv ----
// package for the successive-approximation converter sequencer
package sas_pkg;
   localparam int unsigned SAS_CLK_HZ = 40000000;
   localparam logic [3:0] SAS_OFS_CTRL0  = 4'h0;
   localparam logic [3:0] SAS_OFS_CTRL1  = 4'h1;
   localparam logic [3:0] SAS_OFS_STATUS = 4'h2;
   localparam logic [3:0] SAS_OFS_RES0   = 4'h8;
   localparam logic [6:0] SAS_CYC_SH10   = 7'h21;
   localparam logic [6:0] SAS_CYC_SH8    = 7'h1C;
   localparam logic [6:0] SAS_CYC_NS10   = 7'h3B;
   localparam logic [6:0] SAS_CYC_NS8    = 7'h31;
   localparam logic [6:0] SAS_CYC_SAMPLE = 7'h03;
   localparam logic [3:0] SAS_BITS10     = 4'hA;
   localparam logic [3:0] SAS_BITS8      = 4'h8;
   localparam logic [2:0] SAS_ALT_LAST   = 3'h4;
   typedef enum logic [2:0] {
      SAS_MODE_ONESHOT = 3'b000,
      SAS_MODE_REPEAT  = 3'b001,
      SAS_MODE_SWEEP   = 3'b010,
      SAS_MODE_RSWEEP0 = 3'b011,
      SAS_MODE_RSWEEP1 = 3'b100
   } sas_mode_t;
   typedef enum logic [1:0] {
      SAS_DIV1 = 2'b00,
      SAS_DIV2 = 2'b01,
      SAS_DIV4 = 2'b10
   } sas_div_t;
   typedef enum logic [1:0] {
      SAS_ST_IDLE = 2'b00,
      SAS_ST_CONV = 2'b01
   } sas_state_t;
   // ctrl0: [2:0] mode, [5:3] channel, [6] start, [7] group alt
   // ctrl1: [1:0] div, [2] res10, [3] sh en, [4] vref on, [6:5] sweep len
   typedef struct packed {
      logic       alt;
      logic       start;
      logic [2:0] chan;
      sas_mode_t  mode;
   } sas_ctrl0_t;
   typedef struct packed {
      logic [1:0] sweep;
      logic       vref;
      logic       sh;
      logic       res10;
      sas_div_t   div;
   } sas_ctrl1_t;
endpackage

// ---- verification/sas_seq_tb_top.sv ----
// self-checking bench for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module sas_seq_tb_top
   import sas_pkg::*;
;
   logic        i_sys_clk;
   logic        i_rstn;
   logic [3:0]  i_addr;
   logic [15:0] i_wdata;
   logic        i_wr;
   logic        i_rd;
   logic [15:0] o_rdata;
   logic        i_cmp_hi;
   logic [2:0]  o_mux_sel;
   logic        o_mux_alt;
   logic        o_sample;
   logic        o_vref_on;
   logic [9:0]  o_dac_code;
   logic        o_conv_irq;
   logic [3:0]  vofs;
   logic [9:0]  a;
   int          error_cnt;
   int          n_compared;
   int          n;
   int          pre;
   sas_ctrl0_t  c0;
   sas_ctrl1_t  c1;
   logic        cs_rs [4] = '{1'h1, 1'h0, 1'h1, 1'h0};
   logic        cs_sh [4] = '{1'h1, 1'h1, 1'h0, 1'h0};
   sas_div_t    cs_dv [4] = '{SAS_DIV1, SAS_DIV2, SAS_DIV4, SAS_DIV1};
   int          cs_tm [4] = '{33, 28, 59, 49};
   int          cs_dn [4] = '{1, 2, 4, 1};
   logic [2:0]  cs_ch [4] = '{3'h3, 3'h6, 3'h1, 3'h4};
   logic        cs_al [4] = '{1'h0, 1'h0, 1'h0, 1'h1};

   // each channel gets a distinct level so a misrouted pin shows in the result
   function automatic logic [9:0] ain(input logic [2:0] ch, input logic alt, input logic [3:0] ofs);
      return {ch, alt, ofs, 2'h1};
   endfunction

   // ideal comparator, no settling delay
   assign i_cmp_hi = (ain(o_mux_sel, o_mux_alt, vofs) >= o_dac_code);

   sas_seq uut (
      .i_sys_clk  (i_sys_clk),
      .i_rstn     (i_rstn),
      .i_addr     (i_addr),
      .i_wdata    (i_wdata),
      .i_wr       (i_wr),
      .i_rd       (i_rd),
      .o_rdata    (o_rdata),
      .i_cmp_hi   (i_cmp_hi),
      .o_mux_sel  (o_mux_sel),
      .o_mux_alt  (o_mux_alt),
      .o_sample   (o_sample),
      .o_vref_on  (o_vref_on),
      .o_dac_code (o_dac_code),
      .o_conv_irq (o_conv_irq)
   );

   initial begin
      i_sys_clk = 1'h0;
      forever #12.5 i_sys_clk = ~i_sys_clk;
   end

   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(input logic [3:0] ad, input logic [15:0] d);
      @(posedge i_sys_clk);
      i_wr    <= 1'h1;
      i_addr  <= ad;
      i_wdata <= d;
      @(posedge i_sys_clk);
      i_wr    <= 1'h0;
   endtask

   task automatic rchk(input logic [3:0] ad, input logic [15:0] e, input string nm);
      @(posedge i_sys_clk);
      i_rd   <= 1'h1;
      i_addr <= ad;
      @(posedge i_sys_clk);
      i_rd   <= 1'h0;
      #1;
      chk(nm, o_rdata, e);
   endtask

   task automatic wait_irq(input int lim, output int cnt);
      cnt = 0;
      while (o_conv_irq !== 1'h1) begin
         @(posedge i_sys_clk);
         #1;
         cnt++;
         if (cnt > lim) begin
            error_cnt++;
            $display("[FAIL] irq wait expected 1 seen 0");
            tally_and_finish();
         end
      end
   endtask

   task automatic seq_run(input sas_mode_t m, input logic [14:0] exp);
      logic [14:0] got;
      logic [2:0]  prev;
      int          cyc;
      c0 = '{alt: 1'h0, start: 1'h1, chan: 3'h0, mode: m};
      wr(SAS_OFS_CTRL0, {8'h0, c0});
      @(posedge i_sys_clk);
      #1;
      got  = {12'h0, o_mux_sel};
      prev = o_mux_sel;
      cyc  = 0;
      n    = 1;
      while (n < 5 && cyc < 400) begin
         @(posedge i_sys_clk);
         #1;
         cyc++;
         if (o_mux_sel !== prev) begin
            got  = {got[11:0], o_mux_sel};
            prev = o_mux_sel;
            n++;
         end
      end
      chk("sweep order", {1'h0, got}, {1'h0, exp});
      chk("sweep irq", {15'h0, o_conv_irq}, 16'h0000);
      c0.start = 1'h0;
      wr(SAS_OFS_CTRL0, {8'h0, c0});
      repeat (4) @(posedge i_sys_clk);
   endtask

   initial begin
      i_rstn = 1'h0;
      i_addr = 4'h0;
      i_wdata = 16'h0000;
      i_wr = 1'h0;
      i_rd = 1'h0;
      vofs = 4'h5;
      error_cnt = 0;
      n_compared = 0;
      repeat (6) @(posedge i_sys_clk);
      i_rstn <= 1'h1;
      @(posedge i_sys_clk);
      #1;
      chk("dac code", {6'h0, o_dac_code}, 16'h0200);
      chk("vref", {15'h0, o_vref_on}, 16'h0000);
      rchk(SAS_OFS_CTRL0, 16'h0000, "ctrl0");
      rchk(SAS_OFS_CTRL1, 16'h0002, "ctrl1");
      wr(4'h5, 16'hFFFF);
      rchk(4'h5, 16'h0000, "unmapped");
      $display("reset test done");
      for (int k = 0; k < 4; k++) begin
         c1 = '{sweep: 2'h0, vref: 1'h1, sh: cs_sh[k], res10: cs_rs[k], div: cs_dv[k]};
         c0 = '{alt: cs_al[k], start: 1'h1, chan: cs_ch[k], mode: SAS_MODE_ONESHOT};
         wr(SAS_OFS_CTRL1, {9'h0, c1});
         if (k == 0) begin
            repeat (40000) @(posedge i_sys_clk);
         end
         wr(SAS_OFS_CTRL0, {8'h0, c0});
         @(posedge i_sys_clk);
         #1;
         pre = 1;
         chk("mux sel", {13'h0, o_mux_sel}, {13'h0, cs_ch[k]});
         chk("mux alt", {15'h0, o_mux_alt}, {15'h0, cs_al[k]});
         chk("vref on", {15'h0, o_vref_on}, 16'h0001);
         if (cs_sh[k]) begin
            chk("sample", {15'h0, o_sample}, 16'h0001);
            repeat (3 * cs_dn[k] + 4) @(posedge i_sys_clk);
            #1;
            pre = pre + 3 * cs_dn[k] + 4;
            chk("sample end", {15'h0, o_sample}, 16'h0000);
         end
         wait_irq(300, n);
         n = n + pre;
         chk("conv time", {15'h0, (n >= cs_tm[k] * cs_dn[k]) && (n <= cs_tm[k] * cs_dn[k] + 4)}, 16'h0001);
         a = ain(cs_ch[k], cs_al[k], vofs);
         rchk(SAS_OFS_RES0 + {1'h0, cs_ch[k]}, cs_rs[k] ? {6'h0, a} : {8'h0, a[9:2]}, "result");
         c0.start = 1'h0;
         rchk(SAS_OFS_CTRL0, {8'h0, c0}, "start flag");
         rchk(SAS_OFS_STATUS, {12'h0, cs_ch[k], 1'h1}, "status");
         wr(SAS_OFS_STATUS, 16'h0001);
         rchk(SAS_OFS_STATUS, {12'h0, cs_ch[k], 1'h0}, "status clr");
      end
      $display("oneshot tests done");
      c1 = '{sweep: 2'h0, vref: 1'h1, sh: 1'h1, res10: 1'h1, div: SAS_DIV1};
      wr(SAS_OFS_CTRL1, {9'h0, c1});
      c0 = '{alt: 1'h0, start: 1'h1, chan: 3'h2, mode: SAS_MODE_REPEAT};
      wr(SAS_OFS_CTRL0, {8'h0, c0});
      repeat (90) @(posedge i_sys_clk);
      rchk(SAS_OFS_RES0 + 4'h2, {6'h0, ain(3'h2, 1'h0, vofs)}, "repeat res");
      vofs <= 4'h9;
      repeat (90) @(posedge i_sys_clk);
      rchk(SAS_OFS_RES0 + 4'h2, {6'h0, ain(3'h2, 1'h0, 4'h9)}, "repeat upd");
      chk("repeat irq", {15'h0, o_conv_irq}, 16'h0000);
      c0.start = 1'h0;
      wr(SAS_OFS_CTRL0, {8'h0, c0});
      repeat (2) @(posedge i_sys_clk);
      vofs <= 4'h3;
      repeat (90) @(posedge i_sys_clk);
      rchk(SAS_OFS_RES0 + 4'h2, {6'h0, ain(3'h2, 1'h0, 4'h9)}, "repeat stop");
      $display("repeat test done");
      c1 = '{sweep: 2'h1, vref: 1'h1, sh: 1'h1, res10: 1'h0, div: SAS_DIV1};
      wr(SAS_OFS_CTRL1, {9'h0, c1});
      c0 = '{alt: 1'h0, start: 1'h1, chan: 3'h0, mode: SAS_MODE_SWEEP};
      wr(SAS_OFS_CTRL0, {8'h0, c0});
      @(posedge i_sys_clk);
      #1;
      chk("sweep first", {13'h0, o_mux_sel}, 16'h0000);
      wait_irq(400, n);
      for (int i = 0; i < 4; i++) begin
         a = ain(3'(i), 1'h0, vofs);
         rchk(SAS_OFS_RES0 + 4'(i), {8'h0, a[9:2]}, "sweep res");
      end
      c0.start = 1'h0;
      rchk(SAS_OFS_CTRL0, {8'h0, c0}, "sweep start");
      wr(SAS_OFS_STATUS, 16'h0001);
      $display("sweep test done");
      c1.sweep = 2'h0;
      wr(SAS_OFS_CTRL1, {9'h0, c1});
      seq_run(SAS_MODE_RSWEEP0, {3'h0, 3'h1, 3'h0, 3'h1, 3'h0});
      seq_run(SAS_MODE_RSWEEP1, {3'h0, 3'h1, 3'h0, 3'h2, 3'h0});
      $display("repeated sweep tests done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
